// >>> logic/dao_pkg.sv
package dao_pkg;

  // -----------------------------------------------------------------
  // data widths and conversion pipeline
  // -----------------------------------------------------------------
  localparam int DAO_CODE_W = 10;
  localparam int DAO_MSB_POS = 9;
  localparam int DAO_PIPE_DEPTH = 6;

  // -----------------------------------------------------------------
  // register map, byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] DAO_OFF_CTRL = 8'h00;
  localparam logic [7:0] DAO_OFF_STATUS = 8'h04;
  localparam logic [7:0] DAO_OFF_RESULT_FIRST = 8'h08;
  localparam logic [7:0] DAO_OFF_RESULT_SECOND = 8'h0c;

  // control register fields
  localparam int DAO_CTRL_SOFT_PD_FIRST = 0;
  localparam int DAO_CTRL_SOFT_PD_SECOND = 1;
  localparam logic [1:0] DAO_CTRL_RESET = 2'h0;

  // status register fields
  localparam int DAO_ST_MODE_FIRST = 0;
  localparam int DAO_ST_MODE_SECOND = 2;
  localparam int DAO_ST_TWOS = 4;
  localparam int DAO_ST_STAB = 5;
  localparam int DAO_ST_SWAP = 6;

  // result register fields
  localparam int DAO_RES_FLAG = 10;

  // -----------------------------------------------------------------
  // bus answers
  // -----------------------------------------------------------------
  localparam logic [1:0] DAO_RESP_OKAY = 2'h0;
  localparam logic [1:0] DAO_RESP_SLVERR = 2'h2;

  // -----------------------------------------------------------------
  // format setting levels
  // -----------------------------------------------------------------
  localparam logic [1:0] DAO_LVL_GND = 2'h0;
  localparam logic [1:0] DAO_LVL_THIRD = 2'h1;
  localparam logic [1:0] DAO_LVL_TWO_THIRDS = 2'h2;
  localparam logic [1:0] DAO_LVL_TOP = 2'h3;

  typedef enum logic [1:0] {
    DAO_MODE_NORMAL,
    DAO_MODE_HIZ,
    DAO_MODE_NAP,
    DAO_MODE_SLEEP
  } dao_mode_t;

endpackage

// >>> logic/dao_sync.sv
`timescale 1ns/1ps
module dao_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // -----------------------------------------------------------------
  // two-stage synchroniser
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// >>> logic/dao_pipe.sv
`timescale 1ns/1ps
module dao_pipe #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // one shift per sample edge
  input wire logic shift,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage_r [DEPTH];

  // -----------------------------------------------------------------
  // delay line, read word comes out of a register
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= '0;
      end
      q <= '0;
    end else if (shift) begin
      stage_r[0] <= d;
      for (int i = 1; i < DEPTH; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
      q <= stage_r[DEPTH-1];
    end
  end

endmodule

// >>> logic/dao_top.sv
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module dao_top #(
  parameter int CODE_W = dao_pkg::DAO_CODE_W,
  parameter int PIPE_DEPTH = dao_pkg::DAO_PIPE_DEPTH
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // converter pins, asynchronous to aclk
  input wire logic sample_clock_first,
  input wire logic sample_clock_second,
  input wire logic bus_swap_select,
  input wire logic power_down_first,
  input wire logic power_down_second,
  input wire logic output_enable_low_first,
  input wire logic output_enable_low_second,
  input wire logic [1:0] format_level,
  // quantiser results per channel, asynchronous to aclk
  input wire logic [CODE_W-1:0] sample_code_first,
  input wire logic sample_over_first,
  input wire logic [CODE_W-1:0] sample_code_second,
  input wire logic sample_over_second,
  // first output bus
  output logic [CODE_W-1:0] result_bus_first,
  output logic range_flag_first,
  output logic result_bus_first_oe,
  // second output bus
  output logic [CODE_W-1:0] result_bus_second,
  output logic range_flag_second,
  output logic result_bus_second_oe,
  // shared stabilizer state
  output logic stabilizer_on,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dao_pkg::*;

  localparam int SYNC_W = 2 * CODE_W + 11;

  // -----------------------------------------------------------------
  // pin synchronisation
  // -----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic clk_a_s;
  logic clk_b_s;
  logic swap_s;
  logic pd_a_s;
  logic pd_b_s;
  logic oel_a_s;
  logic oel_b_s;
  logic [1:0] level_s;
  logic [CODE_W-1:0] code_a_s;
  logic [CODE_W-1:0] code_b_s;
  logic over_a_s;
  logic over_b_s;

  assign pins_async = {sample_clock_first, sample_clock_second, bus_swap_select,
                       power_down_first, power_down_second,
                       output_enable_low_first, output_enable_low_second,
                       format_level, sample_over_first, sample_over_second,
                       sample_code_first, sample_code_second};

  dao_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pins_async),
    .q(pins_sync)
  );

  assign {clk_a_s, clk_b_s, swap_s, pd_a_s, pd_b_s, oel_a_s, oel_b_s,
          level_s, over_a_s, over_b_s, code_a_s, code_b_s} = pins_sync;

  // -----------------------------------------------------------------
  // sample edge detection
  // -----------------------------------------------------------------
  logic clk_a_prev_r;
  logic clk_b_prev_r;
  logic edge_a;
  logic edge_b;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_a_prev_r <= 1'b0;
      clk_b_prev_r <= 1'b0;
    end else begin
      clk_a_prev_r <= clk_a_s;
      clk_b_prev_r <= clk_b_s;
    end
  end

  assign edge_a = clk_a_s && !clk_a_prev_r;
  assign edge_b = clk_b_s && !clk_b_prev_r;

  // -----------------------------------------------------------------
  // control register and per-channel mode
  // -----------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic shdn_a;
  logic shdn_b;
  dao_mode_t mode_a;
  dao_mode_t mode_b;
  logic run_a;
  logic run_b;
  logic drive_a;
  logic drive_b;

  // software shutdown adds to the pin, each channel on its own
  assign shdn_a = pd_a_s || ctrl_r[DAO_CTRL_SOFT_PD_FIRST];
  assign shdn_b = pd_b_s || ctrl_r[DAO_CTRL_SOFT_PD_SECOND];

  function automatic dao_mode_t mode_of(input logic shdn, input logic oel);
    dao_mode_t m;
    m = DAO_MODE_NORMAL;
    case ({shdn, oel})
      2'b00: m = DAO_MODE_NORMAL;
      2'b01: m = DAO_MODE_HIZ;
      2'b10: m = DAO_MODE_NAP;
      2'b11: m = DAO_MODE_SLEEP;
      default: m = DAO_MODE_SLEEP;
    endcase
    return m;
  endfunction

  assign mode_a = mode_of(shdn_a, oel_a_s);
  assign mode_b = mode_of(shdn_b, oel_b_s);

  // converting in normal and hi-z modes, pipeline frozen in nap and sleep
  assign run_a = (mode_a == DAO_MODE_NORMAL) || (mode_a == DAO_MODE_HIZ);
  assign run_b = (mode_b == DAO_MODE_NORMAL) || (mode_b == DAO_MODE_HIZ);
  assign drive_a = (mode_a == DAO_MODE_NORMAL);
  assign drive_b = (mode_b == DAO_MODE_NORMAL);

  // -----------------------------------------------------------------
  // shared format decode
  // -----------------------------------------------------------------
  logic twos;
  logic stab;

  always_comb begin
    twos = 1'b0;
    stab = 1'b0;
    case (level_s)
      DAO_LVL_GND: begin
        twos = 1'b0;
        stab = 1'b0;
      end
      DAO_LVL_THIRD: begin
        twos = 1'b0;
        stab = 1'b1;
      end
      DAO_LVL_TWO_THIRDS: begin
        twos = 1'b1;
        stab = 1'b1;
      end
      DAO_LVL_TOP: begin
        twos = 1'b1;
        stab = 1'b0;
      end
      default: begin
        twos = 1'b0;
        stab = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // conversion pipelines
  // -----------------------------------------------------------------
  logic [CODE_W:0] pipe_a_q;
  logic [CODE_W:0] pipe_b_q;

  dao_pipe #(
    .WIDTH(CODE_W + 1),
    .DEPTH(PIPE_DEPTH)
  ) u_pipe_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .shift(edge_a && run_a),
    .d({over_a_s, code_a_s}),
    .q(pipe_a_q)
  );

  dao_pipe #(
    .WIDTH(CODE_W + 1),
    .DEPTH(PIPE_DEPTH)
  ) u_pipe_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .shift(edge_b && run_b),
    .d({over_b_s, code_b_s}),
    .q(pipe_b_q)
  );

  // -----------------------------------------------------------------
  // output format and bus routing
  // -----------------------------------------------------------------
  logic [CODE_W-1:0] word_a;
  logic [CODE_W-1:0] word_b;
  logic flag_a;
  logic flag_b;

  // same format applies to both words
  assign word_a = pipe_a_q[CODE_W-1:0] ^ {twos, {(CODE_W-1){1'b0}}};
  assign word_b = pipe_b_q[CODE_W-1:0] ^ {twos, {(CODE_W-1){1'b0}}};
  assign flag_a = pipe_a_q[CODE_W];
  assign flag_b = pipe_b_q[CODE_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_bus_first <= '0;
      range_flag_first <= 1'b0;
      result_bus_first_oe <= 1'b0;
      result_bus_second <= '0;
      range_flag_second <= 1'b0;
      result_bus_second_oe <= 1'b0;
    end else if (swap_s) begin
      result_bus_first <= word_a;
      range_flag_first <= flag_a;
      result_bus_first_oe <= drive_a;
      result_bus_second <= word_b;
      range_flag_second <= flag_b;
      result_bus_second_oe <= drive_b;
    end else begin
      result_bus_first <= word_b;
      range_flag_first <= flag_b;
      result_bus_first_oe <= drive_b;
      result_bus_second <= word_a;
      range_flag_second <= flag_a;
      result_bus_second_oe <= drive_a;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stabilizer_on <= 1'b0;
    end else begin
      stabilizer_on <= stab;
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite write channel
  // -----------------------------------------------------------------
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DAO_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r[7:2] == DAO_OFF_CTRL[7:2] ||
                      awaddr_r[7:2] == DAO_OFF_STATUS[7:2] ||
                      awaddr_r[7:2] == DAO_OFF_RESULT_FIRST[7:2] ||
                      awaddr_r[7:2] == DAO_OFF_RESULT_SECOND[7:2]) ?
                     DAO_RESP_OKAY : DAO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only the control register takes writes; read-only words ignore them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= DAO_CTRL_RESET;
    end else if (wr_fire && awaddr_r[7:2] == DAO_OFF_CTRL[7:2] && wstrb_r[0]) begin
      ctrl_r <= wdata_r[1:0];
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite read channel
  // -----------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr[7:2])
      DAO_OFF_CTRL[7:2]: begin
        rd_word[1:0] = ctrl_r;
      end
      DAO_OFF_STATUS[7:2]: begin
        rd_word[DAO_ST_MODE_FIRST+1:DAO_ST_MODE_FIRST] = mode_a;
        rd_word[DAO_ST_MODE_SECOND+1:DAO_ST_MODE_SECOND] = mode_b;
        rd_word[DAO_ST_TWOS] = twos;
        rd_word[DAO_ST_STAB] = stab;
        rd_word[DAO_ST_SWAP] = swap_s;
      end
      DAO_OFF_RESULT_FIRST[7:2]: begin
        rd_word[CODE_W-1:0] = word_a;
        rd_word[DAO_RES_FLAG] = flag_a;
      end
      DAO_OFF_RESULT_SECOND[7:2]: begin
        rd_word[CODE_W-1:0] = word_b;
        rd_word[DAO_RES_FLAG] = flag_b;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= DAO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? DAO_RESP_OKAY : DAO_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> test/dao_top_chk.sv
`timescale 1ns/1ps
module dao_top_chk
  import dao_pkg::*;
#(
  parameter int CODE_W = 10,
  parameter int PIPE_DEPTH = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic bus_swap_select,
  input wire logic power_down_first,
  input wire logic output_enable_low_first,
  input wire logic [1:0] format_level,
  // bus outputs
  input wire logic result_bus_first_oe,
  input wire logic result_bus_second_oe,
  input wire logic stabilizer_on,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_idle;
    disable iff (1'b0)
    !aresetn |=> !result_bus_first_oe && !result_bus_second_oe && !stabilizer_on
      && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset");

  property p_nap_off;
    (aresetn && bus_swap_select && power_down_first)[*6] |-> !result_bus_first_oe;
  endproperty
  a_nap_off: assert property (p_nap_off) else $error("bus driven in shutdown");

  property p_hiz_off;
    (aresetn && bus_swap_select && output_enable_low_first)[*6] |-> !result_bus_first_oe;
  endproperty
  a_hiz_off: assert property (p_hiz_off) else $error("bus driven while disabled");

  property p_stab;
    (aresetn && $stable(format_level))[*6] |-> stabilizer_on ==
      (format_level == DAO_LVL_THIRD || format_level == DAO_LVL_TWO_THIRDS);
  endproperty
  a_stab: assert property (p_stab) else $error("stabilizer decode wrong");

  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response not retired");

  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");

  property p_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h03 |=>
      s_axi_rvalid && s_axi_rresp == DAO_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
endmodule

bind dao_top dao_top_chk #(.CODE_W(CODE_W), .PIPE_DEPTH(PIPE_DEPTH)) i_chk (
  .aclk, .aresetn, .bus_swap_select, .power_down_first, .output_enable_low_first,
  .format_level, .result_bus_first_oe, .result_bus_second_oe, .stabilizer_on,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rresp, .s_axi_rdata
);

// >>> test/dao_capture.sv
`timescale 1ns/1ps
module dao_capture (
  // clock
  input wire logic aclk,
  // one device output bus
  input wire logic [9:0] word,
  input wire logic flag,
  input wire logic drive,
  // level seen on the lines
  output logic [10:0] line
);
  // ---------------------------------------------------------------
  // capture
  // ---------------------------------------------------------------
  logic [10:0] held_r = 11'h0;

  // released lines drift to the inverse of the last driven value
  assign line = drive ? {flag, word} : ~held_r;

  always @(posedge aclk) begin
    if (drive) begin
      held_r <= {flag, word};
    end
  end
endmodule

// >>> test/dao_top_bench.sv
`timescale 1ns/1ps
module dao_top_bench;
  import dao_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sample_clock_first = 1'b0, sample_clock_second = 1'b0, bus_swap_select = 1'b1;
  logic power_down_first = 1'b0, power_down_second = 1'b0;
  logic output_enable_low_first = 1'b0, output_enable_low_second = 1'b0;
  logic [1:0] format_level = 2'h0;
  logic [9:0] sample_code_first = 10'h0, sample_code_second = 10'h0;
  logic sample_over_first = 1'b0, sample_over_second = 1'b0;
  logic [9:0] result_bus_first, result_bus_second;
  logic range_flag_first, range_flag_second, result_bus_first_oe, result_bus_second_oe;
  logic stabilizer_on, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [10:0] line_first, line_second, ea = 11'h0, eb = 11'h0;
  logic [10:0] qa[$], qb[$];
  int err_count = 0;
  int checks_done = 0;

  always #5 aclk = ~aclk;

  dao_top i_dut (
    .aclk, .aresetn, .sample_clock_first, .sample_clock_second, .bus_swap_select,
    .power_down_first, .power_down_second, .output_enable_low_first,
    .output_enable_low_second, .format_level, .sample_code_first, .sample_over_first,
    .sample_code_second, .sample_over_second, .result_bus_first, .range_flag_first,
    .result_bus_first_oe, .result_bus_second, .range_flag_second, .result_bus_second_oe,
    .stabilizer_on, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  dao_capture i_cap_first (.aclk, .word(result_bus_first), .flag(range_flag_first),
    .drive(result_bus_first_oe), .line(line_first));
  dao_capture i_cap_second (.aclk, .word(result_bus_second), .flag(range_flag_second),
    .drive(result_bus_second_oe), .line(line_second));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask

  function automatic logic [10:0] fw(input logic [10:0] v);
    return {v[10], v[9] ^ format_level[1], v[8:0]};
  endfunction

  task automatic chk_bus();
    logic oa, ob;
    oa = !power_down_first && !output_enable_low_first;
    ob = !power_down_second && !output_enable_low_second;
    @(negedge aclk);
    chk(stabilizer_on, format_level inside {2'h1, 2'h2});
    chk(result_bus_first_oe, bus_swap_select ? oa : ob);
    chk(result_bus_second_oe, bus_swap_select ? ob : oa);
    if (oa) chk(bus_swap_select ? line_first : line_second, fw(ea));
    if (ob) chk(bus_swap_select ? line_second : line_first, fw(eb));
    @(posedge aclk);
  endtask

  task automatic smp(input logic [10:0] a, input logic [10:0] b, input bit tie);
    {sample_over_first, sample_code_first} <= a;
    {sample_over_second, sample_code_second} <= b;
    @(posedge aclk);
    if (!power_down_first) begin
      qa.push_back(a);
      ea = qa.pop_front();
    end
    if (!power_down_second) begin
      qb.push_back(b);
      eb = qb.pop_front();
    end
    for (int ph = 1; ph >= 0; ph--) begin
      sample_clock_first <= 1'(ph);
      sample_clock_second <= 1'(ph);
      if (tie) bus_swap_select <= 1'(ph);
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      if (tie) chk(line_first, fw(ph ? ea : eb));
      @(posedge aclk);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, da, dw;
    {da, dw} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    do begin
      @(negedge aclk);
      ta = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end while (!ta);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    bit t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_pipe();
    for (int i = 0; i < 10; i++) begin
      smp({i == 1, 10'(i * 113 + 1)}, {i == 2, 10'(10'h3f0 - i * 5)}, 1'b0);
      chk_bus();
    end
  endtask

  task automatic t_regs();
    axi_rd(DAO_OFF_CTRL);
    chk(rd, 32'h0);
    axi_wr(DAO_OFF_CTRL, 32'h3);
    chk(rsp, DAO_RESP_OKAY);
    repeat (5) @(posedge aclk);
    axi_rd(DAO_OFF_STATUS);
    chk(rd, 32'h4a);
    axi_wr(DAO_OFF_CTRL, 32'h0);
    chk(rsp, DAO_RESP_OKAY);
    // control write without its low byte lane must leave the register alone
    s_axi_wstrb <= 4'he;
    axi_wr(DAO_OFF_CTRL, 32'h3);
    s_axi_wstrb <= 4'hf;
    axi_rd(DAO_OFF_CTRL);
    chk(rd, 32'h0);
    axi_wr(DAO_OFF_STATUS, 32'hff);
    chk(rsp, DAO_RESP_OKAY);
    axi_wr(8'h10, 32'h3);
    chk(rsp, DAO_RESP_SLVERR);
    axi_rd(8'h10);
    chk(rsp, DAO_RESP_SLVERR);
    chk(rd, 32'h0);
    axi_rd(DAO_OFF_RESULT_FIRST);
    chk(rd, fw(ea));
    axi_rd(DAO_OFF_RESULT_SECOND);
    chk(rd, fw(eb));
  endtask

  task automatic t_fmt();
    for (int l = 0; l < 8; l++) begin
      {bus_swap_select, format_level} <= 3'(l);
      repeat (5) @(posedge aclk);
      chk_bus();
    end
    format_level <= 2'h0;
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      {power_down_first, output_enable_low_first} <= 2'(m);
      {power_down_second, output_enable_low_second} <= 2'(3 - m);
      repeat (5) @(posedge aclk);
      smp(11'h2aa + 11'(m), 11'h155 - 11'(m), 1'b0);
      chk_bus();
      axi_rd(DAO_OFF_STATUS);
      chk(rd, 32'h40 | 32'((3 - m) << 2) | 32'(m));
      {power_down_first, output_enable_low_first} <= 2'h0;
      {power_down_second, output_enable_low_second} <= 2'h0;
      repeat (5) @(posedge aclk);
      chk_bus();
    end
  endtask

  task automatic t_mux();
    for (int i = 0; i < 3; i++) begin
      smp(11'(i * 7 + 100), 11'(i * 9 + 600), 1'b1);
    end
    bus_swap_select <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    test_done();
  end

  initial begin
    for (int i = 0; i < DAO_PIPE_DEPTH; i++) begin
      qa.push_back(11'h0);
      qb.push_back(11'h0);
    end
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_pipe();
    t_regs();
    t_fmt();
    t_modes();
    t_mux();
    test_done();
  end
endmodule
